// ===== irq_vec_consts.svh
// Constants for the interrupt priority and vectoring block
`ifndef IRQ_VEC_CONSTS_SVH
`define IRQ_VEC_CONSTS_SVH

// ==========================================================
// APB register byte offsets
`define OFF_IRQ_ENABLE_REG      12'h000
`define OFF_IRQ_PRIORITY_REG    12'h004
`define OFF_EXT_ENABLE_REG_A    12'h008
`define OFF_EXT_PRIORITY_REG_A  12'h00c
`define OFF_EXT_ENABLE_REG_B    12'h010
`define OFF_EXT_PRIORITY_REG_B  12'h014
`define OFF_PEND_STATUS         12'h018
`define OFF_ACTIVE_STATUS       12'h01c
`define OFF_EVT_STATUS          12'h020
`define OFF_EVT_MASK            12'h024

// ==========================================================
// Reset values and vector layout
`define RST_PRIO_LOW            8'h00
`define RST_ENABLE              8'h00
`define VEC_RESET               16'h0000
`define VEC_BASE                16'h0003
`define VEC_STEP                16'h0008
`define VEC_LAST                16'h00ab
`define NUM_ORDERS              22
`define ORDER_RSVD_A            5'd13
`define ORDER_RSVD_B            5'd18

// ==========================================================
// Timing, in system clocks
`define T_DETECT                1
`define T_LONG_CALL             5
`define T_MIN_RESPONSE          7
`define T_WORST_RESPONSE        19
`define T_DIVIDE                8

`endif

// ===== irq_vec_pkg.sv
// Types shared by the interrupt vectoring modules
package irq_vec_pkg;
	typedef logic [4:0] order_t;
	typedef logic [21:0] src_vec_t;
	typedef enum logic [1:0] {
		LVL_NONE,
		LVL_LOW,
		LVL_HIGH
	} level_t;
endpackage

// ===== irq_pick_if.sv
// Carries pending requests and the arbiter's choice between modules
`timescale 1ns/1ps
`default_nettype none
interface irq_pick_if;
	import irq_vec_pkg::*;
	src_vec_t req;
	src_vec_t prio;
	logic     found;
	order_t   order;
	logic     high;
	modport arb (input req, input prio, output found, output order,
		output high);
	modport top (output req, output prio, input found, input order,
		input high);
endinterface
`default_nettype wire

// ===== irq_arbiter.sv
// Combinational two-level priority arbiter over the source orders
`timescale 1ns/1ps
`default_nettype none
module irq_arbiter
	import irq_vec_pkg::*;
#(
	parameter int N = 22
) (
	irq_pick_if.arb pick
);
	src_vec_t hi_req;

	assign hi_req = pick.req & pick.prio;

	// High level wins first, then lowest order number
	always_comb begin
		pick.found = 1'b0;
		pick.order = '0;
		pick.high  = 1'b0;
		for (int i = N - 1; i >= 0; i--) begin
			if (pick.req[i]) begin
				pick.found = 1'b1;
				pick.order = order_t'(i);
			end
		end
		for (int i = N - 1; i >= 0; i--) begin
			if (hi_req[i]) begin
				pick.order = order_t'(i);
				pick.high  = 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ===== irq_vectoring.sv
// Interrupt priority, vectoring and response sequencing for the core
`timescale 1ns/1ps
`default_nettype none
`include "irq_vec_consts.svh"

module irq_vectoring
	import irq_vec_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [21:0] src_pend,
	input  wire logic        port_match,
	input  wire logic        instr_done,
	input  wire logic        return_from_isr_instr,
	output logic             long_call_instr,
	output logic      [15:0] vector_addr,
	output logic             clr_ext_irq_zero,
	output logic             clr_ext_irq_one,
	output logic             clr_tmr0_ovf,
	output logic             clr_tmr1_ovf,
	output logic             irq
);
	// ==========================================================
	// Registers
	logic [7:0] irq_enable_reg_q;
	logic [7:0] irq_priority_reg_q;
	logic [7:0] ext_enable_reg_a_q;
	logic [7:0] ext_priority_reg_a_q;
	logic [7:0] ext_enable_reg_b_q;
	logic [7:0] ext_priority_reg_b_q;
	logic [2:0] evt_status_q;
	logic [2:0] evt_mask_q;
	src_vec_t   pend_q;
	logic       in_low_q;
	logic       in_high_q;
	logic       low_was_preempted_q;
	logic       call_q;
	logic [2:0] call_cnt_q;

	src_vec_t   en_all;
	src_vec_t   prio_all;
	src_vec_t   req_raw;
	src_vec_t   req_ok;
	logic       wr_en;
	logic       rd_en;
	logic       may_take;
	logic       take;
	logic [2:0] evt_set;
	logic [31:0] rdata_d;

	irq_pick_if pick ();

	// ==========================================================
	// Enable and priority maps, one bit per order
	always_comb begin
		en_all   = '0;
		prio_all = '0;
		en_all[6:0]     = irq_enable_reg_q[6:0];
		prio_all[6:0]   = irq_priority_reg_q[6:0];
		en_all[14:7]    = ext_enable_reg_a_q;
		prio_all[14:7]  = ext_priority_reg_a_q;
		en_all[21:15]   = ext_enable_reg_b_q[6:0];
		prio_all[21:15] = ext_priority_reg_b_q[6:0];
		en_all[13] = 1'b0;
		en_all[18] = 1'b0;
	end

	// ==========================================================
	// Request sampling
	// Pending inputs come from peripherals on this same clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend_q <= '0;
		end else begin
			pend_q     <= src_pend;
			pend_q[16] <= port_match;
		end
	end

	// Read-only flags such as supply warning rely on enable alone
	assign req_raw = pend_q & en_all;
	assign pick.req  = req_raw;
	assign pick.prio = prio_all;

	irq_arbiter #(
		.N (`NUM_ORDERS)
	) u_arb (
		.pick (pick.arb)
	);

	// Preemption gate: nothing over high, only high over low
	always_comb begin
		req_ok = req_raw;
		if (in_high_q) begin
			req_ok = '0;
		end else if (in_low_q) begin
			req_ok = req_raw & prio_all;
		end
	end

	// A call only follows a completed instruction; after a return
	// the next instruction must also finish
	assign may_take = instr_done && !return_from_isr_instr && !call_q;
	assign take = may_take && (|req_ok) && pick.found &&
		(!in_low_q || pick.high);

	// ==========================================================
	// Active levels
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in_low_q            <= 1'b0;
			in_high_q           <= 1'b0;
			low_was_preempted_q <= 1'b0;
		end else if (take) begin
			if (pick.high) begin
				in_high_q           <= 1'b1;
				low_was_preempted_q <= in_low_q;
			end else begin
				in_low_q <= 1'b1;
			end
		end else if (instr_done && return_from_isr_instr) begin
			if (in_high_q) begin
				in_high_q <= 1'b0;
				// Low level stays active so its routine finishes
				in_low_q  <= low_was_preempted_q;
				low_was_preempted_q <= 1'b0;
			end else begin
				in_low_q <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Long call sequencer: five clocks of call
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			call_q       <= 1'b0;
			call_cnt_q   <= '0;
		end else if (take) begin
			call_q       <= 1'b1;
			call_cnt_q   <= 3'(`T_LONG_CALL - 1);
		end else if (call_q) begin
			if (call_cnt_q == 3'h0) begin
				call_q <= 1'b0;
			end else begin
				call_cnt_q <= call_cnt_q - 3'h1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			long_call_instr <= 1'b0;
			vector_addr     <= `VEC_RESET;
		end else begin
			long_call_instr <= take;
			if (take) begin
				vector_addr <= `VEC_BASE +
					(16'(pick.order) << 3);
			end
		end
	end

	// Edge-style flags are cleared by hardware on vectoring
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clr_ext_irq_zero <= 1'b0;
			clr_ext_irq_one  <= 1'b0;
			clr_tmr0_ovf     <= 1'b0;
			clr_tmr1_ovf     <= 1'b0;
		end else begin
			clr_ext_irq_zero <= take && pick.order == 5'd0;
			clr_tmr0_ovf     <= take && pick.order == 5'd1;
			clr_ext_irq_one  <= take && pick.order == 5'd2;
			clr_tmr1_ovf     <= take && pick.order == 5'd3;
		end
	end

	// ==========================================================
	// APB slave: zero wait states, unmapped reads give zero
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && !penable && !pwrite;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_enable_reg_q     <= `RST_ENABLE;
			irq_priority_reg_q   <= `RST_PRIO_LOW;
			ext_enable_reg_a_q   <= `RST_ENABLE;
			ext_priority_reg_a_q <= `RST_PRIO_LOW;
			ext_enable_reg_b_q   <= `RST_ENABLE;
			ext_priority_reg_b_q <= `RST_PRIO_LOW;
			evt_mask_q           <= 3'h0;
		end else if (wr_en) begin
			unique case (paddr)
				`OFF_IRQ_ENABLE_REG:     irq_enable_reg_q     <= pwdata[7:0];
				`OFF_IRQ_PRIORITY_REG:   irq_priority_reg_q   <= pwdata[7:0];
				`OFF_EXT_ENABLE_REG_A:   ext_enable_reg_a_q   <= pwdata[7:0];
				`OFF_EXT_PRIORITY_REG_A: ext_priority_reg_a_q <= pwdata[7:0];
				`OFF_EXT_ENABLE_REG_B:   ext_enable_reg_b_q   <= pwdata[7:0];
				`OFF_EXT_PRIORITY_REG_B: ext_priority_reg_b_q <= pwdata[7:0];
				`OFF_EVT_MASK:           evt_mask_q           <= pwdata[2:0];
				default: ;
			endcase
		end
	end

	// Events: bit0 vector taken, bit1 high preempted low, bit2 return
	assign evt_set = {instr_done && return_from_isr_instr,
		take && pick.high && in_low_q, take};

	// Set wins over a write-one clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			evt_status_q <= 3'h0;
		end else begin
			if (wr_en && paddr == `OFF_EVT_STATUS) begin
				evt_status_q <= (evt_status_q & ~pwdata[2:0]) | evt_set;
			end else begin
				evt_status_q <= evt_status_q | evt_set;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |((evt_status_q | evt_set) & evt_mask_q);
		end
	end

	always_comb begin
		rdata_d = 32'h0000_0000;
		unique case (paddr)
			`OFF_IRQ_ENABLE_REG:     rdata_d[7:0] = irq_enable_reg_q;
			`OFF_IRQ_PRIORITY_REG:   rdata_d[7:0] = irq_priority_reg_q;
			`OFF_EXT_ENABLE_REG_A:   rdata_d[7:0] = ext_enable_reg_a_q;
			`OFF_EXT_PRIORITY_REG_A: rdata_d[7:0] = ext_priority_reg_a_q;
			`OFF_EXT_ENABLE_REG_B:   rdata_d[7:0] = ext_enable_reg_b_q;
			`OFF_EXT_PRIORITY_REG_B: rdata_d[7:0] = ext_priority_reg_b_q;
			`OFF_PEND_STATUS:        rdata_d[21:0] = pend_q;
			`OFF_ACTIVE_STATUS:      rdata_d[2:0] =
				{low_was_preempted_q, in_high_q, in_low_q};
			`OFF_EVT_STATUS:         rdata_d[2:0] = evt_status_q;
			`OFF_EVT_MASK:           rdata_d[2:0] = evt_mask_q;
			default: ;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= 1'b0;
			if (rd_en) begin
				prdata <= rdata_d;
			end
		end
	end
endmodule
`default_nettype wire

// ===== irq_flag_model.sv
// Peripheral pending flag model that sits on the far side of the block
`timescale 1ns/1ps
`default_nettype none
module irq_flag_model (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [21:0] set_pend,
	input  wire logic [21:0] sw_clr,
	input  wire logic [3:0]  hw_clr,
	output logic      [21:0] src_pend
);
	logic [21:0] flag_q;

	// ==========================================================
	// Flags
	// A flag stays up until software drops it; flags 0 to 3 also drop on the vectoring pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			flag_q <= 22'h0;
		else
			flag_q <= (flag_q | set_pend) & ~sw_clr & ~{18'h0, hw_clr};
	end
	assign src_pend = flag_q;
endmodule
`default_nettype wire

// ===== irq_vectoring_chk.sv
// Port assertions for the interrupt vectoring block
`timescale 1ns/1ps
`default_nettype none
module irq_vectoring_chk (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [21:0] src_pend,
	input wire logic        port_match,
	input wire logic        instr_done,
	input wire logic        return_from_isr_instr,
	input wire logic        long_call_instr,
	input wire logic [15:0] vector_addr,
	input wire logic        clr_ext_irq_zero,
	input wire logic        clr_ext_irq_one
);
	// ==========================================================
	// Bus and call sequencing
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_ready; psel && !penable |=> pready && !pslverr; endproperty
	a_ready: assert property (p_ready) else $error("bad access answer");
	property p_gap; long_call_instr |=> !long_call_instr [*5]; endproperty
	a_gap: assert property (p_gap) else $error("calls too close");
	property p_cause;
		long_call_instr |-> $past(instr_done) && !$past(return_from_isr_instr);
	endproperty
	a_cause: assert property (p_cause) else $error("call on return");
	property p_vec;
		long_call_instr |-> vector_addr[2:0] == 3'h3 && vector_addr <= 16'h00ab;
	endproperty
	a_vec: assert property (p_vec) else $error("bad vector");
	property p_rsvd;
		long_call_instr |-> vector_addr != 16'h006b && vector_addr != 16'h0093;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved vector");
	property p_hold; !long_call_instr |-> $stable(vector_addr); endproperty
	a_hold: assert property (p_hold) else $error("vector moved");
	property p_src;
		long_call_instr |-> $past(src_pend, 2) != 22'h0 || $past(port_match, 2);
	endproperty
	a_src: assert property (p_src) else $error("call without request");
	property p_clr0;
		clr_ext_irq_zero |-> long_call_instr && vector_addr == 16'h0003;
	endproperty
	a_clr0: assert property (p_clr0) else $error("stray clear zero");
	property p_clr2;
		clr_ext_irq_one |-> long_call_instr && vector_addr == 16'h0013;
	endproperty
	a_clr2: assert property (p_clr2) else $error("stray clear one");
endmodule
bind irq_vectoring irq_vectoring_chk u_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
	.src_pend(src_pend), .port_match(port_match), .instr_done(instr_done),
	.return_from_isr_instr(return_from_isr_instr),
	.long_call_instr(long_call_instr), .vector_addr(vector_addr),
	.clr_ext_irq_zero(clr_ext_irq_zero), .clr_ext_irq_one(clr_ext_irq_one));
`default_nettype wire

// ===== tb_irq_vectoring.sv
// Self-checking bench for the interrupt vectoring block
`timescale 1ns/1ps
`default_nettype none
module tb_irq_vectoring;
	logic        pclk, presetn, psel, penable, pwrite, port_match, i0, i1;
	logic        instr_done, return_from_isr_instr, pready, pslverr, irq;
	logic        long_call_instr, c0, c1, c2, c3;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [15:0] vector_addr;
	logic [21:0] src_pend, set_pend, sw_clr;
	int          err_total = 0;
	int          checked = 0;
	int          cyc = 0;

	irq_vectoring uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.src_pend(src_pend), .port_match(port_match), .instr_done(instr_done),
		.return_from_isr_instr(return_from_isr_instr),
		.long_call_instr(long_call_instr), .vector_addr(vector_addr),
		.clr_ext_irq_zero(c0), .clr_tmr0_ovf(c1), .clr_ext_irq_one(c2),
		.clr_tmr1_ovf(c3), .irq(irq));
	irq_flag_model flags_m (.pclk(pclk), .presetn(presetn),
		.set_pend(set_pend), .sw_clr(sw_clr), .hw_clr({c3, c2, c1, c0}),
		.src_pend(src_pend));

	initial begin
		pclk = 1'h0;
		forever #25 pclk = ~pclk;
	end

	// ==========================================================
	// Shared tasks
	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		q = prdata;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask

	task automatic flags(input logic [21:0] s, input logic [21:0] c);
		set_pend <= s;
		sw_clr <= c;
		@(posedge pclk);
		set_pend <= 22'h0;
		sw_clr <= 22'h0;
		@(posedge pclk);
	endtask

	// One instruction completes; then whether a call starts, and where
	task automatic op(input logic r, input logic c, input logic [15:0] v);
		instr_done <= 1'h1;
		return_from_isr_instr <= r;
		@(posedge pclk);
		instr_done <= 1'h0;
		return_from_isr_instr <= 1'h0;
		@(negedge pclk);
		chk("long_call_instr", {31'h0, c}, {31'h0, long_call_instr});
		if (c)
			chk("vector_addr", {16'h0, v}, {16'h0, vector_addr});
		repeat (6) @(posedge pclk);
	endtask

	task automatic irq_now(output logic v);
		@(posedge pclk);
		@(negedge pclk);
		v = irq;
		@(posedge pclk);
	endtask

	// ==========================================================
	// Scenarios
	task automatic s_reset();
		for (int i = 1; i < 6; i += 2) begin
			apb(1'h0, 12'(i * 4), 32'h0);
			chk("priority", 32'h0, q);
		end
		apb(1'h0, 12'h030, 32'h0);
		chk("unmapped", 32'h0, q);
		chk("vector_addr", 32'h0, {16'h0, vector_addr});
	endtask

	task automatic s_order();
		apb(1'h1, 12'h000, 32'h7f);
		apb(1'h1, 12'h008, 32'hff);
		apb(1'h1, 12'h010, 32'h7e);
		flags(22'h14, 22'h0);
		op(1'h0, 1'h1, 16'h0013);
		op(1'h0, 1'h0, 16'h0);
		op(1'h1, 1'h0, 16'h0);
		op(1'h0, 1'h1, 16'h0023);
		flags(22'h0, 22'h10);
		op(1'h1, 1'h0, 16'h0);
	endtask

	task automatic s_preempt();
		apb(1'h1, 12'h004, 32'h40);
		apb(1'h1, 12'h00c, 32'h04);
		flags(22'h241, 22'h0);
		op(1'h0, 1'h1, 16'h0033);
		op(1'h0, 1'h0, 16'h0);
		flags(22'h0, 22'h40);
		op(1'h1, 1'h0, 16'h0);
		op(1'h0, 1'h1, 16'h004b);
		flags(22'h0, 22'h200);
		op(1'h1, 1'h0, 16'h0);
		op(1'h0, 1'h1, 16'h0003);
		flags(22'h200, 22'h0);
		op(1'h0, 1'h1, 16'h004b);
		flags(22'h0, 22'h200);
		op(1'h1, 1'h0, 16'h0);
		apb(1'h0, 12'h01c, 32'h0);
		chk("active", 32'h1, q);
		op(1'h1, 1'h0, 16'h0);
		apb(1'h0, 12'h01c, 32'h0);
		chk("active", 32'h0, q);
	endtask

	task automatic s_gating();
		flags(22'h0a000, 22'h0);
		flags(22'h40000, 22'h0);
		op(1'h0, 1'h0, 16'h0);
		flags(22'h0, 22'h42000);
		port_match <= 1'h1;
		@(posedge pclk);
		op(1'h0, 1'h1, 16'h0083);
		port_match <= 1'h0;
		op(1'h1, 1'h0, 16'h0);
		apb(1'h1, 12'h010, 32'h7f);
		op(1'h0, 1'h1, 16'h007b);
		apb(1'h1, 12'h010, 32'h7e);
		op(1'h1, 1'h0, 16'h0);
		op(1'h0, 1'h0, 16'h0);
	endtask

	task automatic s_timers();
		flags(22'h00a, 22'h0);
		op(1'h0, 1'h1, 16'h000b);
		op(1'h1, 1'h0, 16'h0);
		op(1'h0, 1'h1, 16'h001b);
		op(1'h1, 1'h0, 16'h0);
		chk("src_pend", 32'h8000, {10'h0, src_pend});
	endtask

	// A mask bit of one lets its status bit reach irq
	task automatic s_events();
		apb(1'h0, 12'h020, 32'h0);
		chk("evt_status", 32'h7, q);
		apb(1'h1, 12'h024, 32'h0);
		irq_now(i0);
		apb(1'h1, 12'h024, 32'h7);
		irq_now(i1);
		chk("irq_masked", 32'h0, {31'h0, i0});
		chk("irq_unmasked", 32'h1, {31'h0, i1});
		apb(1'h1, 12'h020, 32'h7);
		apb(1'h0, 12'h020, 32'h0);
		chk("evt_status", 32'h0, q);
		irq_now(i0);
		chk("irq", 32'h0, {31'h0, i0});
	endtask

	task automatic results();
		if (err_total == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			err_total++;
			results();
		end
	end

	initial begin
		{psel, penable, pwrite, port_match} = 4'h0;
		{instr_done, return_from_isr_instr, presetn} = 3'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		set_pend = 22'h0;
		sw_clr = 22'h0;
		repeat (4) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		s_reset();
		s_order();
		s_preempt();
		s_gating();
		s_timers();
		s_events();
		results();
	end
endmodule
`default_nettype wire
